/* hdl/eoc_pkg.sv */
package eoc_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int ADDR_W       = 3;
  localparam int CODE_W       = 8;
  localparam int FRAME_W      = 12;
  localparam int MSGS_PER_SF  = 2;
  localparam int TLL_COUNT    = 3;
  localparam int DATA_LIMIT   = 3;

  // ****************************************
  // Addresses and codes
  // ****************************************
  localparam logic [2:0] ADDR_TERMINAL  = 3'h0;
  localparam logic [2:0] ADDR_BROADCAST = 3'h7;
  localparam logic [7:0] CODE_FULL_LOOP = 8'h50;
  localparam logic [7:0] CODE_LOOP_B1   = 8'h51;
  localparam logic [7:0] CODE_LOOP_B2   = 8'h52;
  localparam logic [7:0] CODE_CC_REQ    = 8'h53;
  localparam logic [7:0] CODE_CC_NOTE   = 8'h54;
  localparam logic [7:0] CODE_NORMAL    = 8'hff;
  localparam logic [7:0] CODE_HOLD      = 8'h00;
  localparam logic [7:0] CODE_NO_COMPLY = 8'haa;
  localparam logic [3:0] MON0_NIBBLE    = 4'h0;
  localparam logic [7:0] STATE_INIT     = 8'hff;

  // ****************************************
  // APB register map
  // ****************************************
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LAST   = 8'h08;
  localparam logic [7:0] OFF_HOSTTX = 8'h0c;
  localparam int         MODE_AUTO_BIT = 0;
  localparam logic       MODE_RESET    = 1'b1;

  // Transceiver states; all but LS_OTHER carry superframes
  typedef enum logic [2:0] {
    LS_OTHER, LS_SYNC, LS_WAIT_ACT, LS_TRANSP, LS_ERR_ST, LS_PEND_DEAC
  } line_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic       kind;
    logic [7:0] code;
  } eoc_frame_t;

  typedef struct packed {
    logic loop_b1;
    logic loop_b2;
    logic cc_req;
    logic cc_note;
  } latch_t;

  function automatic logic [15:0] mon0_pack(input eoc_frame_t f);
    mon0_pack = {MON0_NIBBLE, f.addr, f.kind, f.code};
  endfunction

  function automatic logic superframe_state(input line_state_t s);
    superframe_state = (s == LS_SYNC) || (s == LS_WAIT_ACT) || (s == LS_TRANSP) ||
                       (s == LS_ERR_ST) || (s == LS_PEND_DEAC);
  endfunction

endpackage

/* hdl/eoc_shift.sv */
`timescale 1ns/10ps
// Serial in/out for one 12-bit message on the overhead slots
module eoc_shift
  import eoc_pkg::*;
(
  // Clock
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Slot strobe and line bits
  input  wire logic             slot,
  input  wire logic             rx_bit,
  input  wire eoc_frame_t       tx_frame,
  input  wire logic             tx_enable,
  // Results
  output      eoc_frame_t       rx_frame,
  output      logic             rx_done,
  output      logic             tx_bit
);

  typedef struct packed {
    logic [FRAME_W-1:0] rx_sr;
    logic [FRAME_W-1:0] tx_sr;
    logic [3:0]         cnt;
    eoc_frame_t         frame;
    logic               done;
    logic               txb;
  } sh_t;

  sh_t st_r, st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (slot) begin
      // Address first, then kind, then code, msb leading
      st_nxt.rx_sr = {st_r.rx_sr[FRAME_W-2:0], rx_bit}; // [R1] [R2]
      if (st_r.cnt == 4'(FRAME_W - 1)) begin
        st_nxt.cnt   = 4'h0;
        st_nxt.frame = eoc_frame_t'({st_r.rx_sr[FRAME_W-2:0], rx_bit});
        st_nxt.done  = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
      if (st_r.cnt == 4'h0) begin
        st_nxt.txb   = tx_frame[FRAME_W-1];
        st_nxt.tx_sr = {tx_frame[FRAME_W-2:0], 1'b1};
      end else begin
        st_nxt.txb   = st_r.tx_sr[FRAME_W-1];
        st_nxt.tx_sr = {st_r.tx_sr[FRAME_W-2:0], 1'b1};
      end
      if (!tx_enable)
        st_nxt.txb = 1'b1; // [R7]
    end
    if (!tx_enable) begin
      st_nxt.txb = 1'b1;
      st_nxt.cnt = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{rx_sr: '1, tx_sr: '1, cnt: 4'h0, frame: '1, done: 1'b0, txb: 1'b1};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rx_frame = st_r.frame;
  assign rx_done  = st_r.done;
  assign tx_bit   = st_r.txb;

endmodule

/* hdl/eoc_processor.sv */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
// Overview of operation
// [R1] Channel bits ride the M1-M3 overhead slots
// [R2] Message: address, kind flag, eight-bit code
// [R3] Address 0 terminal, 1-6 repeaters, 7 broadcast
// [R4] Kind 1 means code, 0 means data
// [R5] Decode loop, checksum, normal and hold codes
// [R6] Auto or transparent by mode bit, auto default
// [R7] Send ones outside superframe-carrying states
// [R8] Monitor message: nibble 0, address, kind, code
// [R9] Auto mode echoes each frame at once
// [R10] Foreign address answered with hold, address 0; a third data frame in a row gets unable-to-comply, own address
// [R11] Unable-to-comply after three data frames or bad code
// [R12] Commands stay latched until normal or deactivation
// [R13] One monitor message per new code; host ignored
// [R14] Execute only addressed messages passing repetition check
// [R15] Full loop only raises a loop indication
// [R16] Codes 0x51/0x52 loop bearer channel one/two
// [R17] Checksum request: invert upstream, far-end counting off
// [R18] Checksum notice: near-end counting and indications off
// [R19] Normal code releases all, state back to 0xff
// [R20] Transparent mode forwards every frame to host
// [R21] Host acknowledges and runs tests in transparent mode
// [R22] Transparent mode sends latest host code upstream
// [R23] Host issues local normal after return-to-normal
// [R24] Local corrupt command needs earlier exchange request
// [R25] Repetition check: three identical consecutive messages
module eoc_processor
  import eoc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Line side
  input  wire logic        slot,
  input  wire logic        line_rx_bit,
  input  wire line_state_t line_state,
  input  wire logic        deactivate,
  output      logic        line_tx_bit,
  // Host monitor channel
  input  wire logic        host_msg_valid,
  input  wire logic [15:0] host_msg,
  input  wire logic        send_corrupt_checksum_command,
  input  wire logic        local_normal_command,
  output      logic        mon_valid,
  output      logic [15:0] mon_msg,
  // Test function controls
  output      logic        first_loop_indication,
  output      logic        second_loop_indication,
  output      logic        first_bearer_loopback,
  output      logic        second_bearer_loopback,
  output      logic        invert_checksum,
  output      logic        far_end_block_error_disable,
  output      logic        near_end_block_error_disable
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic        rx_s1;
    logic        rx_s2;
    logic        auto_mode_bit;
    eoc_frame_t  echo;
    eoc_frame_t  cand;
    logic [1:0]  rep;
    logic [7:0]  proc_state;
    logic [1:0]  data_cnt;
    latch_t      lat;
    logic        cc_seen;
    logic        pend_normal;
    eoc_frame_t  host_frame;
    logic        mvalid;
    logic [15:0] mmsg;
    logic        ind1;
    logic        ind2;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } proc_t;

  proc_t st_r, st_nxt;

  eoc_frame_t rx_frame;
  logic       rx_done;
  logic       tx_bit;
  eoc_frame_t tx_frame;
  logic       sf_ok;
  logic       transp_now;

  function automatic logic addr_ok(input eoc_frame_t f);
    addr_ok = (f.addr == ADDR_TERMINAL) || (f.addr == ADDR_BROADCAST); // [R3]
  endfunction

  function automatic logic code_known(input logic [7:0] c);
    code_known = (c == CODE_FULL_LOOP) || (c == CODE_LOOP_B1) || (c == CODE_LOOP_B2) ||
                 (c == CODE_CC_REQ) || (c == CODE_CC_NOTE) || (c == CODE_NORMAL) ||
                 (c == CODE_HOLD); // [R5]
  endfunction

  // ****************************************
  // Serial slot engine
  // ****************************************
  assign sf_ok    = superframe_state(line_state); // [R7]
  assign tx_frame = st_r.auto_mode_bit ? st_r.echo : st_r.host_frame;

  eoc_shift u_shift (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .slot      (slot),
    .rx_bit    (st_r.rx_s2),
    .tx_frame  (tx_frame),
    .tx_enable (sf_ok),
    .rx_frame  (rx_frame),
    .rx_done   (rx_done),
    .tx_bit    (tx_bit)
  );

  assign transp_now = (line_state == LS_TRANSP);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic       same;
    logic       passed;
    st_nxt        = st_r;
    same          = 1'b0;
    passed        = 1'b0;
    st_nxt.rx_s1  = line_rx_bit;
    st_nxt.rx_s2  = st_r.rx_s1;
    st_nxt.mvalid = 1'b0;
    st_nxt.ready  = 1'b0;
    st_nxt.err    = 1'b0;

    // APB: one wait state, then answer
    if (psel && penable && !st_r.ready) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0;
      unique case (paddr)
        OFF_MODE:   st_nxt.rdata = {31'h0, st_r.auto_mode_bit};
        OFF_STATUS: st_nxt.rdata = {18'h0, st_r.proc_state, st_r.cc_seen,
                                    st_r.lat, st_r.pend_normal};
        OFF_LAST:   st_nxt.rdata = {20'h0, st_r.cand};
        OFF_HOSTTX: st_nxt.rdata = {20'h0, st_r.host_frame};
        default:    st_nxt.err   = 1'b1;
      endcase
    end

    // Write lands only on the edge that completes the transfer
    if (psel && penable && st_r.ready && pwrite && (paddr == OFF_MODE))
      st_nxt.auto_mode_bit = pwdata[MODE_AUTO_BIT]; // [R6]

    // Ahead of the frame logic so a received set wins over a clear
    if (!st_r.auto_mode_bit) begin
      // Host messages only count in transparent mode
      if (host_msg_valid && host_msg[15:12] == MON0_NIBBLE)
        st_nxt.host_frame = eoc_frame_t'(host_msg[11:0]); // [R22] [R21]
      if (send_corrupt_checksum_command && st_r.cc_seen)
        st_nxt.lat.cc_req = 1'b1; // [R24]
      if (local_normal_command && st_r.pend_normal) begin
        st_nxt.lat         = '0; // [R23]
        st_nxt.cc_seen     = 1'b0;
        st_nxt.pend_normal = 1'b0;
      end
    end

    if (rx_done && sf_ok) begin
      if (st_r.auto_mode_bit) begin
        // Echo at once, answered before the repetition check
        st_nxt.echo = rx_frame; // [R9]
        if (!addr_ok(rx_frame))
          st_nxt.echo = '{addr: ADDR_TERMINAL, kind: 1'b1, code: CODE_HOLD}; // [R10]
        if (!rx_frame.kind) begin
          if (st_r.data_cnt == 2'(DATA_LIMIT - 1)) begin
            st_nxt.echo     = '{addr: rx_frame.addr, kind: 1'b1, code: CODE_NO_COMPLY}; // [R11]
            st_nxt.data_cnt = 2'h0;
          end else begin
            st_nxt.data_cnt = st_r.data_cnt + 2'h1; // [R4]
          end
        end else begin
          st_nxt.data_cnt = 2'h0;
          if (addr_ok(rx_frame) && !code_known(rx_frame.code))
            st_nxt.echo = '{addr: rx_frame.addr, kind: 1'b1, code: CODE_NO_COMPLY}; // [R11]
        end
        // Three identical consecutive messages
        same = (rx_frame == st_r.cand);
        st_nxt.cand = rx_frame;
        if (!same)
          st_nxt.rep = 2'h1;
        else if (st_r.rep != 2'(TLL_COUNT))
          st_nxt.rep = st_r.rep + 2'h1; // [R25]
        passed = same && (st_r.rep == 2'(TLL_COUNT - 1)) &&
                 (rx_frame.code != st_r.proc_state);
        if (passed) begin
          st_nxt.proc_state = rx_frame.code;
          st_nxt.mvalid     = 1'b1;
          st_nxt.mmsg       = mon0_pack(rx_frame); // [R13] [R8]
          if (addr_ok(rx_frame) && rx_frame.kind) begin // [R14]
            unique case (rx_frame.code)
              CODE_FULL_LOOP: begin
                // Loop is left to the downstream device
                st_nxt.ind1 = transp_now; // [R15]
                st_nxt.ind2 = (line_state == LS_ERR_ST) || (line_state == LS_SYNC);
              end
              CODE_LOOP_B1: st_nxt.lat.loop_b1 = 1'b1; // [R16] [R12]
              CODE_LOOP_B2: st_nxt.lat.loop_b2 = 1'b1; // [R16]
              CODE_CC_REQ: begin
                st_nxt.lat.cc_req = 1'b1; // [R17]
                st_nxt.cc_seen    = 1'b1;
              end
              CODE_CC_NOTE: st_nxt.lat.cc_note = 1'b1; // [R18]
              CODE_NORMAL: begin
                st_nxt.lat        = '0; // [R19]
                st_nxt.ind1       = 1'b0;
                st_nxt.ind2       = 1'b0;
                st_nxt.cc_seen    = 1'b0;
                st_nxt.proc_state = STATE_INIT;
              end
              default: ;
            endcase
          end
        end
      end else begin
        // Transparent: every frame goes to host, no check
        st_nxt.mvalid = 1'b1;
        st_nxt.mmsg   = mon0_pack(rx_frame); // [R20] [R8]
        if (rx_frame.kind && rx_frame.code == CODE_CC_REQ)
          st_nxt.cc_seen = 1'b1;
        if (rx_frame.kind && rx_frame.code == CODE_NORMAL)
          st_nxt.pend_normal = 1'b1; // [R23]
      end
    end

    if (deactivate) begin
      st_nxt.lat         = '0; // [R12]
      st_nxt.ind1        = 1'b0;
      st_nxt.ind2        = 1'b0;
      st_nxt.cc_seen     = 1'b0;
      st_nxt.pend_normal = 1'b0;
      st_nxt.proc_state  = STATE_INIT;
      st_nxt.rep         = 2'h0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{rx_s1: 1'b1, rx_s2: 1'b1, auto_mode_bit: MODE_RESET,
                echo: '{addr: ADDR_TERMINAL, kind: 1'b1, code: CODE_HOLD},
                cand: '1, rep: 2'h0, proc_state: STATE_INIT, data_cnt: 2'h0,
                lat: '0, cc_seen: 1'b0, pend_normal: 1'b0,
                host_frame: '{addr: ADDR_TERMINAL, kind: 1'b1, code: CODE_HOLD},
                mvalid: 1'b0, mmsg: 16'h0, ind1: 1'b0, ind2: 1'b0,
                rdata: 32'h0, ready: 1'b0, err: 1'b0}; // [R6]
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata                       = st_r.rdata;
  assign pready                       = st_r.ready;
  assign pslverr                      = st_r.err;
  assign line_tx_bit                  = tx_bit;
  assign mon_valid                    = st_r.mvalid;
  assign mon_msg                      = st_r.mmsg;
  assign first_loop_indication        = st_r.ind1;
  assign second_loop_indication       = st_r.ind2;
  assign first_bearer_loopback        = st_r.lat.loop_b1;
  assign second_bearer_loopback       = st_r.lat.loop_b2;
  assign invert_checksum              = st_r.lat.cc_req; // [R17]
  assign far_end_block_error_disable  = st_r.lat.cc_req; // [R17]
  assign near_end_block_error_disable = st_r.lat.cc_note; // [R18]

endmodule

/* sim/eoc_chk.sv */
`timescale 1ns/10ps
module eoc_chk
  import eoc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line and host
  input wire logic        slot,
  input wire line_state_t line_state,
  input wire logic        deactivate,
  input wire logic        line_tx_bit,
  input wire logic        mon_valid,
  input wire logic [15:0] mon_msg,
  // Controls
  input wire logic        first_loop_indication,
  input wire logic        second_loop_indication,
  input wire logic        first_bearer_loopback,
  input wire logic        second_bearer_loopback,
  input wire logic        invert_checksum
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Properties
  // ****************************************
  a_ones_idle: assert property ((line_state == LS_OTHER) [*2] |-> line_tx_bit)
    else $error("channel bit not idle high");
  a_mon_nibble: assert property (mon_valid |-> mon_msg[15:12] == 4'h0)
    else $error("monitor message nibble wrong");
  a_mon_slot: assert property (mon_valid |-> $past(slot, 2) || $past(slot, 3))
    else $error("monitor message not tied to a frame end");
  a_mon_single: assert property (mon_valid |=> !mon_valid)
    else $error("monitor message repeated");
  a_loop_excl: assert property (!(first_loop_indication && second_loop_indication))
    else $error("both loop indications high");
  a_deact_clear: assert property (deactivate |-> ##[1:3] !(first_bearer_loopback ||
    second_bearer_loopback || invert_checksum))
    else $error("latched commands survive deactivation");
  a_apb_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("register answer not after one wait state");
  a_unmapped_err: assert property (psel && penable && pready &&
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && pready &&
    (paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |-> !pslverr)
    else $error("mapped access refused");
endmodule
bind eoc_processor eoc_chk eoc_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .slot(slot),
  .line_state(line_state), .deactivate(deactivate), .line_tx_bit(line_tx_bit),
  .mon_valid(mon_valid), .mon_msg(mon_msg), .first_loop_indication(first_loop_indication),
  .second_loop_indication(second_loop_indication), .first_bearer_loopback(first_bearer_loopback),
  .second_bearer_loopback(second_bearer_loopback), .invert_checksum(invert_checksum));

/* sim/line_terminal_model.sv */
`timescale 1ns/10ps
module line_terminal_model
  import eoc_pkg::*;
(
  // Clock
  input  wire logic pclk,
  // Line bits
  output      logic slot,
  output      logic line_rx_bit,
  input  wire logic line_tx_bit
);
  eoc_frame_t last_tx;
  initial begin
    slot = 1'b0;
    line_rx_bit = 1'b1;
  end
  // ****************************************
  // One message on twelve strobes
  // ****************************************
  task automatic send_frame(input eoc_frame_t f);
    logic [11:0] bits;
    bits = f;
    for (int i = 11; i >= 0; i--) begin
      line_rx_bit <= bits[i];
      repeat (3) @(posedge pclk);
      slot <= 1'b1;
      @(posedge pclk);
      slot <= 1'b0;
      repeat (2) @(posedge pclk);
      last_tx[i] = line_tx_bit;
      // Toggle afterwards so a stale level never passes for data
      line_rx_bit <= ~bits[i];
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask
endmodule

/* sim/embedded_ops_channel_processor_bench.sv */
`timescale 1ns/10ps
module embedded_ops_channel_processor_bench;
  import eoc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        deactivate = 1'b0, host_msg_valid = 1'b0, ccc = 1'b0, ce = 1'b1, lnc = 1'b0;
  logic [7:0]  paddr = 8'h00, pst = 8'hff;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] host_msg = 16'h0, mon_msg;
  logic        slot, line_rx_bit, pready, pslverr, err, line_tx_bit, mon_valid;
  logic        fli, sli, fbl, sbl, inv, fed, ned, auto_m = 1'b1, echo_ok = 1'b0;
  line_state_t line_state = LS_SYNC;
  int          mismatches = 0, tests_run = 0, run = 0, dcnt = 0;
  logic [15:0] mon_q[$];
  eoc_frame_t  last_f = 12'h0, exp_echo = 12'h0, nxt_echo;
  logic [11:0] emask = 12'hfff;
  logic [2:0]  ta[10] = '{3'h0, 3'h0, 3'h7, 3'h0, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [7:0]  tc[10] = '{8'h51, 8'h53, 8'h54, 8'hff, 8'h50, 8'hff, 8'h50, 8'hff, 8'h52, 8'h54};
  logic [6:0]  te[10] = '{7'h10, 7'h16, 7'h17, 7'h00, 7'h40, 7'h00, 7'h20, 7'h00, 7'h08, 7'h09};
  line_state_t ts[10] = '{LS_SYNC, LS_SYNC, LS_SYNC, LS_SYNC, LS_TRANSP, LS_TRANSP, LS_ERR_ST,
                          LS_SYNC, LS_SYNC, LS_SYNC};
  eoc_processor eoc_processor_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slot(slot), .line_rx_bit(line_rx_bit),
    .line_state(line_state), .deactivate(deactivate), .line_tx_bit(line_tx_bit),
    .host_msg_valid(host_msg_valid), .host_msg(host_msg), .send_corrupt_checksum_command(ccc),
    .local_normal_command(lnc), .mon_valid(mon_valid), .mon_msg(mon_msg),
    .first_loop_indication(fli), .second_loop_indication(sli), .first_bearer_loopback(fbl),
    .second_bearer_loopback(sbl), .invert_checksum(inv), .far_end_block_error_disable(fed),
    .near_end_block_error_disable(ned));
  line_terminal_model line_terminal_model_inst (.pclk(pclk), .slot(slot),
    .line_rx_bit(line_rx_bit), .line_tx_bit(line_tx_bit));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ctrl(input logic [6:0] exp);
    chk("controls", {25'h0, exp}, {25'h0, fli, sli, fbl, sbl, inv, fed, ned});
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Model runs first so the expected message is queued before it arrives
  task automatic send(input eoc_frame_t f);
    nxt_echo = exp_echo;
    if (auto_m) begin
      run = (f === last_f) ? run + 1 : 1;
      last_f = f;
      dcnt = f.kind ? 0 : dcnt + 1;
      nxt_echo = f;
      if (f.addr != 3'h0 && f.addr != 3'h7) nxt_echo = 12'h100;
      else if (dcnt == 3 || (f.kind && !(f.code inside {8'h50, 8'h51, 8'h52, 8'h53, 8'h54,
               8'hff, 8'h00}))) nxt_echo = {f.addr, 1'b1, 8'haa};
      if (run == 3 && f.code != pst) begin
        mon_q.push_back({4'h0, f});
        pst = f.code;
      end
    end else mon_q.push_back({4'h0, f});
    line_terminal_model_inst.send_frame(f);
    if (echo_ok) chk("echo", {20'h0, exp_echo & emask},
      {20'h0, line_terminal_model_inst.last_tx & emask});
    emask = (auto_m && nxt_echo.code == 8'haa) ? 12'h1ff : 12'hfff;
    exp_echo = nxt_echo;
    if (auto_m) echo_ok = 1'b1;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial forever #4 pclk = ~pclk;
  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
  always @(posedge pclk) begin
    if (mon_valid === 1'b1) begin
      if (mon_q.size() == 0) chk("mon_extra", 32'hffffffff, {16'h0, mon_msg});
      else chk("mon_msg", {16'h0, mon_q.pop_front()}, {16'h0, mon_msg});
    end
  end
  initial begin
    void'($urandom(32'h952e));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ctrl(7'h00);
    chk("tx_idle", 32'h1, {31'h0, line_tx_bit});
    apb(1'b0, 8'h00, 32'h0);
    chk("mode", 32'h1, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("reset test done");
    for (int i = 0; i < 3; i++) send({3'h3, 1'b1, 8'h52});
    ctrl(7'h00);
    for (int i = 1; i < 4; i++) send({3'h0, 1'b0, 8'(i)});
    send({3'h0, 1'b1, 8'h77});
    $display("address and data test done");
    for (int i = 0; i < 10; i++) begin
      line_state <= ts[i];
      send({ta[i], 1'b1, tc[i]});
      send({ta[i], 1'b1, tc[i]});
      ctrl(i == 0 ? 7'h00 : te[i - 1]);
      send({ta[i], 1'b1, tc[i]});
      ctrl(te[i]);
      if (tc[i] == 8'hff) begin
        apb(1'b0, 8'h04, 32'h0);
        chk("proc_state", 32'hff, {24'h0, rd[13:6]});
      end
    end
    // Enable low must hold the latches against deactivation
    ce <= 1'b0;
    deactivate <= 1'b1;
    repeat (2) @(posedge pclk);
    ctrl(te[9]);
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    deactivate <= 1'b0;
    pst = 8'hff;
    repeat (4) @(posedge pclk);
    ctrl(7'h00);
    $display("command test done");
    line_state <= LS_OTHER;
    repeat (4) @(posedge pclk);
    chk("tx_idle", 32'h1, {31'h0, line_tx_bit});
    line_state <= LS_SYNC;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("mode", 32'h0, rd);
    auto_m = 1'b0;
    exp_echo = {3'h0, 1'b1, 8'($urandom)};
    emask = 12'hfff;
    host_msg <= {4'h0, exp_echo};
    host_msg_valid <= 1'b1;
    @(posedge pclk);
    host_msg_valid <= 1'b0;
    ccc <= 1'b1;
    @(posedge pclk);
    ccc <= 1'b0;
    echo_ok = 1'b1;
    for (int i = 0; i < 3; i++) send({3'h0, 1'b1, 8'h51});
    ctrl(7'h00);
    send({3'h0, 1'b1, 8'h53});
    ccc <= 1'b1;
    @(posedge pclk);
    ccc <= 1'b0;
    @(posedge pclk);
    ctrl(7'h06);
    send({3'h0, 1'b1, 8'hff});
    ctrl(7'h06);
    lnc <= 1'b1;
    @(posedge pclk);
    lnc <= 1'b0;
    @(posedge pclk);
    ctrl(7'h00);
    send({3'($urandom), 1'b1, 8'($urandom)});
    ctrl(7'h00);
    chk("mon_left", 32'h0, 32'(mon_q.size()));
    $display("transparent test done");
    wrap_up();
  end
endmodule
